// ---- hdl/revfb_pkg.sv ----
package revfb_pkg;

   // ----------------------------------------
   // flag bank layout
   // ----------------------------------------
   localparam int NFLAGS = 17;
   typedef logic [NFLAGS-1:0] revfb_flags_t;
   typedef logic [11:0] revfb_addr_t;

   localparam revfb_addr_t ADDRESS_MISS_EVENT_OFF = 12'h118;
   localparam revfb_addr_t STRENGTH_SAMPLE_DONE_EVENT_OFF = 12'h11c;
   localparam revfb_addr_t BIT_COUNT_MATCH_EVENT_OFF = 12'h128;
   localparam revfb_addr_t CRC_PASS_EVENT_OFF = 12'h130;
   localparam revfb_addr_t CRC_FAIL_EVENT_OFF = 12'h134;
   localparam revfb_addr_t FRAME_START_EVENT_OFF = 12'h138;
   localparam revfb_addr_t ENERGY_DETECT_DONE_EVENT_OFF = 12'h13c;
   localparam revfb_addr_t ENERGY_DETECT_STOPPED_EVENT_OFF = 12'h140;
   localparam revfb_addr_t CHANNEL_IDLE_EVENT_OFF = 12'h144;
   localparam revfb_addr_t CHANNEL_BUSY_EVENT_OFF = 12'h148;
   localparam revfb_addr_t CHANNEL_ASSESS_STOPPED_EVENT_OFF = 12'h14c;
   localparam revfb_addr_t RATE_BOOST_EVENT_OFF = 12'h150;
   localparam revfb_addr_t TRANSMIT_READY_EVENT_OFF = 12'h154;
   localparam revfb_addr_t RECEIVE_READY_EVENT_OFF = 12'h158;
   localparam revfb_addr_t HEADER_MATCH_EVENT_OFF = 12'h15c;
   localparam revfb_addr_t PREAMBLE_SYNC_EVENT_OFF = 12'h168;
   localparam revfb_addr_t PHY_END_EVENT_OFF = 12'h16c;

   // index of each flag equals its position in this table
   localparam revfb_addr_t FLAG_OFFS [NFLAGS] = '{
      ADDRESS_MISS_EVENT_OFF, STRENGTH_SAMPLE_DONE_EVENT_OFF, BIT_COUNT_MATCH_EVENT_OFF,
      CRC_PASS_EVENT_OFF, CRC_FAIL_EVENT_OFF, FRAME_START_EVENT_OFF,
      ENERGY_DETECT_DONE_EVENT_OFF, ENERGY_DETECT_STOPPED_EVENT_OFF, CHANNEL_IDLE_EVENT_OFF,
      CHANNEL_BUSY_EVENT_OFF, CHANNEL_ASSESS_STOPPED_EVENT_OFF, RATE_BOOST_EVENT_OFF,
      TRANSMIT_READY_EVENT_OFF, RECEIVE_READY_EVENT_OFF, HEADER_MATCH_EVENT_OFF,
      PREAMBLE_SYNC_EVENT_OFF, PHY_END_EVENT_OFF};

   localparam int IDX_ADDR_MISS = 0;
   localparam int IDX_STRENGTH = 1;
   localparam int IDX_BIT_MATCH = 2;
   localparam int IDX_CRC_PASS = 3;
   localparam int IDX_CRC_FAIL = 4;
   localparam int IDX_FRAME_START = 5;
   localparam int IDX_ED_DONE = 6;
   localparam int IDX_ED_STOPPED = 7;
   localparam int IDX_CH_IDLE = 8;
   localparam int IDX_CH_BUSY = 9;
   localparam int IDX_CCA_STOPPED = 10;
   localparam int IDX_RATE_BOOST = 11;
   localparam int IDX_TX_READY = 12;
   localparam int IDX_RX_READY = 13;
   localparam int IDX_HDR_MATCH = 14;
   localparam int IDX_SYNC = 15;
   localparam int IDX_PHY_END = 16;

   // ----------------------------------------
   // control and interrupt registers
   // ----------------------------------------
   localparam revfb_addr_t IRQ_STATUS_OFF = 12'h300;
   localparam revfb_addr_t IRQ_CLEAR_OFF = 12'h304;
   localparam revfb_addr_t IRQ_ENABLE_OFF = 12'h308;
   localparam revfb_addr_t BIT_COUNTER_COMPARE_OFF = 12'h310;
   localparam revfb_addr_t BIT_COUNTER_VALUE_OFF = 12'h314;
   localparam revfb_addr_t RX_RATE_STATE_OFF = 12'h318;

   localparam logic FLAG_CLEAR_VALUE = 1'b0;
   localparam revfb_flags_t FLAGS_RESET = 17'h00000;
   localparam logic [31:0] COMPARE_RESET = 32'h00000000;

   // ----------------------------------------
   // radio mode codes and bus answers
   // ----------------------------------------
   localparam logic [2:0] LONG_RANGE_125K_MODE = 3'h1;
   localparam logic [2:0] LONG_RANGE_500K_MODE = 3'h2;
   localparam logic [2:0] LOWRATE_PAN_250K_MODE = 3'h3;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : revfb_pkg

// ---- hdl/revfb_flag_if.sv ----
`timescale 1ns/1ns
interface revfb_flag_if #(parameter int N = 17);
   logic [N-1:0] set;
   logic [N-1:0] clr;
   logic [N-1:0] flags;
   modport owner (input set, input clr, output flags);
   modport user (output set, output clr, input flags);
endinterface : revfb_flag_if

// ---- hdl/revfb_sticky.sv ----
`timescale 1ns/1ns
module revfb_sticky #(
   parameter int N = 17
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // flag vector
   revfb_flag_if.owner fl
);

   logic [N-1:0] flags_reg;

   // ----------------------------------------
   // sticky bits, set beats clear
   // ----------------------------------------
   always_ff @(posedge clk) begin
      if (rst) begin
         flags_reg <= '0;
      end else begin
         flags_reg <= (flags_reg & ~fl.clr) | fl.set;
      end
   end

   assign fl.flags = flags_reg;

endmodule : revfb_sticky

// ---- hdl/revfb_bank.sv ----
// Register access over AXI4-Lite was decided locally.
`timescale 1ns/1ns
module revfb_bank #(
   parameter int BC_WIDTH = 16
) (
   // clock and reset
   input wire logic CLK,
   input wire logic SYS_RST,
   // axi4-lite write address
   input wire logic AWVALID,
   output logic AWREADY,
   input wire logic [11:0] AWADDR,
   input wire logic [2:0] AWPROT,
   // axi4-lite write data
   input wire logic WVALID,
   output logic WREADY,
   input wire logic [31:0] WDATA,
   input wire logic [3:0] WSTRB,
   // axi4-lite write response
   output logic BVALID,
   input wire logic BREADY,
   output logic [1:0] BRESP,
   // axi4-lite read address
   input wire logic ARVALID,
   output logic ARREADY,
   input wire logic [11:0] ARADDR,
   input wire logic [2:0] ARPROT,
   // axi4-lite read data
   output logic RVALID,
   input wire logic RREADY,
   output logic [31:0] RDATA,
   output logic [1:0] RRESP,
   // radio core condition pulses
   input wire logic EV_ADDR_MISS,
   input wire logic EV_STRENGTH_DONE,
   input wire logic EV_CRC_PASS,
   input wire logic EV_CRC_FAIL,
   input wire logic EV_LENGTH_FIELD,
   input wire logic EV_ED_DONE,
   input wire logic EV_ED_STOPPED,
   input wire logic EV_CCA_IDLE,
   input wire logic EV_CCA_BUSY,
   input wire logic EV_CCA_STOPPED,
   input wire logic EV_CODING_IND,
   input wire logic EV_TX_RAMPED,
   input wire logic EV_RX_RAMPED,
   input wire logic EV_HDR_MATCH,
   input wire logic EV_PREAMBLE,
   input wire logic EV_PHY_END,
   // radio core state
   input wire logic [2:0] RADIO_MODE,
   input wire logic RX_ACTIVE,
   input wire logic BC_START,
   input wire logic BC_STOP,
   input wire logic BIT_TICK,
   // outputs to core and system
   output logic RX_RATE_500K,
   output logic IRQ
);

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   function automatic logic [5:0] flag_lookup(input logic [11:0] a);
      logic [5:0] r;
      r = 6'h00;
      for (int i = 0; i < revfb_pkg::NFLAGS; i++) begin
         if (a == revfb_pkg::FLAG_OFFS[i]) begin
            r = {1'b1, 5'(i)};
         end
      end
      return r;
   endfunction : flag_lookup

   function automatic logic [31:0] strobe_merge(input logic [31:0] old, input logic [31:0] nw,
                                                input logic [3:0] strb);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) begin
            r[8*b +: 8] = nw[8*b +: 8];
         end
      end
      return r;
   endfunction : strobe_merge

   revfb_flag_if #(.N(revfb_pkg::NFLAGS)) ev_if ();
   revfb_flag_if #(.N(revfb_pkg::NFLAGS)) irq_if ();

   logic aw_ready_reg;
   logic aw_held_reg;
   logic [11:0] aw_addr_reg;
   logic w_ready_reg;
   logic w_held_reg;
   logic [31:0] w_data_reg;
   logic [3:0] w_strb_reg;
   logic b_valid_reg;
   logic [1:0] b_resp_reg;
   logic ar_ready_reg;
   logic r_valid_reg;
   logic [31:0] r_data_reg;
   logic [1:0] r_resp_reg;
   logic [31:0] enable_reg;
   logic [31:0] bc_cmp_reg;
   logic [BC_WIDTH-1:0] bc_count_reg;
   logic bc_armed_reg;
   logic rate_500k_reg;
   logic irq_reg;
   logic wr_fire;
   logic [5:0] wr_hit;
   logic [5:0] rd_hit;
   logic bc_match;
   logic lr_or_pan;

   // ----------------------------------------
   // flag storage
   // ----------------------------------------
   revfb_sticky #(.N(revfb_pkg::NFLAGS)) u_events (
      .clk(CLK),
      .rst(SYS_RST),
      .fl(ev_if.owner)
   );

   revfb_sticky #(.N(revfb_pkg::NFLAGS)) u_irq_status (
      .clk(CLK),
      .rst(SYS_RST),
      .fl(irq_if.owner)
   );

   // ----------------------------------------
   // condition to flag mapping
   // ----------------------------------------
   assign bc_match = bc_armed_reg && (32'(bc_count_reg) == bc_cmp_reg);
   assign lr_or_pan = (RADIO_MODE == revfb_pkg::LONG_RANGE_125K_MODE)
                      || (RADIO_MODE == revfb_pkg::LONG_RANGE_500K_MODE)
                      || (RADIO_MODE == revfb_pkg::LOWRATE_PAN_250K_MODE);

   always_comb begin
      ev_if.set = '0;
      ev_if.set[revfb_pkg::IDX_ADDR_MISS] = EV_ADDR_MISS;
      ev_if.set[revfb_pkg::IDX_STRENGTH] = EV_STRENGTH_DONE;
      ev_if.set[revfb_pkg::IDX_BIT_MATCH] = bc_match;
      ev_if.set[revfb_pkg::IDX_CRC_PASS] = EV_CRC_PASS;
      ev_if.set[revfb_pkg::IDX_CRC_FAIL] = EV_CRC_FAIL;
      ev_if.set[revfb_pkg::IDX_FRAME_START] = EV_LENGTH_FIELD
         && (RADIO_MODE == revfb_pkg::LOWRATE_PAN_250K_MODE);
      ev_if.set[revfb_pkg::IDX_ED_DONE] = EV_ED_DONE;
      ev_if.set[revfb_pkg::IDX_ED_STOPPED] = EV_ED_STOPPED;
      ev_if.set[revfb_pkg::IDX_CH_IDLE] = EV_CCA_IDLE;
      ev_if.set[revfb_pkg::IDX_CH_BUSY] = EV_CCA_BUSY;
      ev_if.set[revfb_pkg::IDX_CCA_STOPPED] = EV_CCA_STOPPED;
      ev_if.set[revfb_pkg::IDX_RATE_BOOST] = EV_CODING_IND && RX_ACTIVE;
      ev_if.set[revfb_pkg::IDX_TX_READY] = EV_TX_RAMPED;
      ev_if.set[revfb_pkg::IDX_RX_READY] = EV_RX_RAMPED;
      ev_if.set[revfb_pkg::IDX_HDR_MATCH] = EV_HDR_MATCH;
      ev_if.set[revfb_pkg::IDX_SYNC] = EV_PREAMBLE && RX_ACTIVE && lr_or_pan;
      ev_if.set[revfb_pkg::IDX_PHY_END] = EV_PHY_END;
   end

   assign irq_if.set = ev_if.set;

   // ----------------------------------------
   // software clears
   // ----------------------------------------
   assign wr_fire = aw_held_reg && w_held_reg && !b_valid_reg;
   assign wr_hit = flag_lookup(aw_addr_reg);

   always_comb begin
      ev_if.clr = '0;
      if (wr_fire && wr_hit[5] && w_strb_reg[0] && (w_data_reg[0] == revfb_pkg::FLAG_CLEAR_VALUE)) begin
         ev_if.clr[wr_hit[4:0]] = 1'b1;
      end
   end

   always_comb begin
      irq_if.clr = '0;
      if (wr_fire && (aw_addr_reg == revfb_pkg::IRQ_CLEAR_OFF)) begin
         irq_if.clr = revfb_pkg::revfb_flags_t'(strobe_merge(32'h00000000, w_data_reg, w_strb_reg));
      end
   end

   // ----------------------------------------
   // write channels
   // ----------------------------------------
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         aw_ready_reg <= 1'b0;
         aw_held_reg <= 1'b0;
         aw_addr_reg <= 12'h000;
      end else if (AWVALID && aw_ready_reg) begin
         aw_ready_reg <= 1'b0;
         aw_held_reg <= 1'b1;
         aw_addr_reg <= AWADDR;
      end else if (wr_fire) begin
         aw_held_reg <= 1'b0;
      end else if (!aw_held_reg && !b_valid_reg) begin
         aw_ready_reg <= 1'b1;
      end
   end

   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         w_ready_reg <= 1'b0;
         w_held_reg <= 1'b0;
         w_data_reg <= 32'h00000000;
         w_strb_reg <= 4'h0;
      end else if (WVALID && w_ready_reg) begin
         w_ready_reg <= 1'b0;
         w_held_reg <= 1'b1;
         w_data_reg <= WDATA;
         w_strb_reg <= WSTRB;
      end else if (wr_fire) begin
         w_held_reg <= 1'b0;
      end else if (!w_held_reg && !b_valid_reg) begin
         w_ready_reg <= 1'b1;
      end
   end

   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         b_valid_reg <= 1'b0;
         b_resp_reg <= revfb_pkg::RESP_OKAY;
      end else if (wr_fire) begin
         b_valid_reg <= 1'b1;
         b_resp_reg <= (wr_hit[5] || aw_addr_reg == revfb_pkg::IRQ_CLEAR_OFF
                        || aw_addr_reg == revfb_pkg::IRQ_ENABLE_OFF
                        || aw_addr_reg == revfb_pkg::BIT_COUNTER_COMPARE_OFF)
                       ? revfb_pkg::RESP_OKAY : revfb_pkg::RESP_SLVERR;
      end else if (BREADY) begin
         b_valid_reg <= 1'b0;
      end
   end

   // ----------------------------------------
   // control registers
   // ----------------------------------------
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         enable_reg <= revfb_pkg::COMPARE_RESET;
      end else if (wr_fire && aw_addr_reg == revfb_pkg::IRQ_ENABLE_OFF) begin
         enable_reg <= strobe_merge(enable_reg, w_data_reg, w_strb_reg)
                       & 32'(revfb_pkg::revfb_flags_t'('1));
      end
   end

   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         bc_cmp_reg <= revfb_pkg::COMPARE_RESET;
      end else if (wr_fire && aw_addr_reg == revfb_pkg::BIT_COUNTER_COMPARE_OFF) begin
         bc_cmp_reg <= strobe_merge(bc_cmp_reg, w_data_reg, w_strb_reg);
      end
   end

   // ----------------------------------------
   // bit counter
   // ----------------------------------------
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         bc_armed_reg <= 1'b0;
         bc_count_reg <= '0;
      end else if (BC_START) begin
         bc_armed_reg <= 1'b1;
         bc_count_reg <= '0;
      end else if (BC_STOP || bc_match) begin
         bc_armed_reg <= 1'b0;
      end else if (bc_armed_reg && BIT_TICK) begin
         bc_count_reg <= bc_count_reg + 1'b1;
      end
   end

   // ----------------------------------------
   // receive rate tracking
   // ----------------------------------------
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         rate_500k_reg <= 1'b0;
      end else if (EV_CODING_IND && RX_ACTIVE) begin
         rate_500k_reg <= 1'b1;
      end else if (EV_PHY_END || !RX_ACTIVE) begin
         rate_500k_reg <= 1'b0;
      end
   end

   // ----------------------------------------
   // interrupt
   // ----------------------------------------
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         irq_reg <= 1'b0;
      end else begin
         irq_reg <= |(irq_if.flags & enable_reg[revfb_pkg::NFLAGS-1:0]);
      end
   end

   // ----------------------------------------
   // read channel
   // ----------------------------------------
   assign rd_hit = flag_lookup(ARADDR);

   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         ar_ready_reg <= 1'b0;
         r_valid_reg <= 1'b0;
         r_data_reg <= 32'h00000000;
         r_resp_reg <= revfb_pkg::RESP_OKAY;
      end else if (ARVALID && ar_ready_reg) begin
         ar_ready_reg <= 1'b0;
         r_valid_reg <= 1'b1;
         r_resp_reg <= revfb_pkg::RESP_OKAY;
         r_data_reg <= 32'h00000000;
         if (rd_hit[5]) begin
            r_data_reg <= {31'h00000000, ev_if.flags[rd_hit[4:0]]};
         end else if (ARADDR == revfb_pkg::IRQ_STATUS_OFF) begin
            r_data_reg <= 32'(irq_if.flags);
         end else if (ARADDR == revfb_pkg::IRQ_ENABLE_OFF) begin
            r_data_reg <= enable_reg;
         end else if (ARADDR == revfb_pkg::BIT_COUNTER_COMPARE_OFF) begin
            r_data_reg <= bc_cmp_reg;
         end else if (ARADDR == revfb_pkg::BIT_COUNTER_VALUE_OFF) begin
            r_data_reg <= 32'(bc_count_reg);
         end else if (ARADDR == revfb_pkg::RX_RATE_STATE_OFF) begin
            r_data_reg <= {31'h00000000, rate_500k_reg};
         end else begin
            r_resp_reg <= revfb_pkg::RESP_SLVERR;
         end
      end else if (r_valid_reg && RREADY) begin
         r_valid_reg <= 1'b0;
      end else if (!r_valid_reg) begin
         ar_ready_reg <= 1'b1;
      end
   end

   assign AWREADY = aw_ready_reg;
   assign WREADY = w_ready_reg;
   assign BVALID = b_valid_reg;
   assign BRESP = b_resp_reg;
   assign ARREADY = ar_ready_reg;
   assign RVALID = r_valid_reg;
   assign RDATA = r_data_reg;
   assign RRESP = r_resp_reg;
   assign RX_RATE_500K = rate_500k_reg;
   assign IRQ = irq_reg;

   // ----------------------------------------
   // checks
   // ----------------------------------------
   default clocking @(posedge CLK); endclocking
   default disable iff (SYS_RST);

   property p_addr_miss;
      EV_ADDR_MISS |=> ev_if.flags[0];
   endproperty
   a_addr_miss: assert property (p_addr_miss) else $error("address miss flag not set");

   property p_strength;
      EV_STRENGTH_DONE |=> ev_if.flags[1];
   endproperty
   a_strength: assert property (p_strength) else $error("strength flag not set");

   sequence s_bc_hit;
      bc_armed_reg && !BC_START && (32'(bc_count_reg) == bc_cmp_reg);
   endsequence
   property p_bc_match;
      s_bc_hit |=> ev_if.flags[2] && !bc_armed_reg;
   endproperty
   a_bc_match: assert property (p_bc_match) else $error("bit count match missed");

   property p_crc;
      (EV_CRC_PASS |=> ev_if.flags[3]) and (EV_CRC_FAIL |=> ev_if.flags[4]);
   endproperty
   a_crc: assert property (p_crc) else $error("crc flag not set");

   sequence s_length_in_pan;
      EV_LENGTH_FIELD && RADIO_MODE == revfb_pkg::LOWRATE_PAN_250K_MODE;
   endsequence
   property p_frame_start;
      (s_length_in_pan |=> ev_if.flags[5])
      and ($rose(ev_if.flags[5]) |-> $past(EV_LENGTH_FIELD && RADIO_MODE == revfb_pkg::LOWRATE_PAN_250K_MODE));
   endproperty
   a_frame_start: assert property (p_frame_start) else $error("frame start outside pan mode");

   property p_ed;
      (EV_ED_DONE |=> ev_if.flags[6]) and (EV_ED_STOPPED |=> ev_if.flags[7]);
   endproperty
   a_ed: assert property (p_ed) else $error("energy detect flag not set");

   property p_cca;
      (EV_CCA_IDLE |=> ev_if.flags[8]) and (EV_CCA_BUSY |=> ev_if.flags[9])
      and (EV_CCA_STOPPED |=> ev_if.flags[10]) and (EV_HDR_MATCH |=> ev_if.flags[14]);
   endproperty
   a_cca: assert property (p_cca) else $error("assessment flag not set");

   sequence s_ci_seen;
      EV_CODING_IND && RX_ACTIVE;
   endsequence
   property p_rate_boost;
      s_ci_seen |=> ev_if.flags[11] && RX_RATE_500K;
   endproperty
   a_rate_boost: assert property (p_rate_boost) else $error("rate boost not applied");

   property p_ramp;
      (EV_TX_RAMPED |=> ev_if.flags[12]) and (EV_RX_RAMPED |=> ev_if.flags[13]);
   endproperty
   a_ramp: assert property (p_ramp) else $error("ramp flag not set");

   property p_sync;
      $rose(ev_if.flags[15]) |-> $past(EV_PREAMBLE && RX_ACTIVE && lr_or_pan);
   endproperty
   a_sync: assert property (p_sync) else $error("sync flag without preamble");

   property p_phy_end;
      EV_PHY_END && !(EV_CODING_IND && RX_ACTIVE) |=> ev_if.flags[16] && !RX_RATE_500K;
   endproperty
   a_phy_end: assert property (p_phy_end) else $error("phy end flag not set");

   property p_sticky;
      1 |=> ((($past(ev_if.flags) & ~$past(ev_if.clr)) & ~ev_if.flags) == '0);
   endproperty
   a_sticky: assert property (p_sticky) else $error("flag dropped without clear");

endmodule : revfb_bank

// ---- bench/revfb_bank_tb.sv ----
`timescale 1ns/1ns
module revfb_bank_tb;
   // ----------------------------------------
   // signals
   // ----------------------------------------
   logic clk = 0;
   logic rst = 1;
   logic awvalid = 0;
   logic wvalid = 0;
   logic bready = 0;
   logic arvalid = 0;
   logic rready = 0;
   logic [11:0] awaddr = '0;
   logic [11:0] araddr = '0;
   logic [31:0] wdata = '0;
   logic [31:0] rd;
   logic [1:0] rsp;
   logic [19:0] pv = '0;
   logic [2:0] mode = 3'h3;
   logic rx_act = 1;
   wire awready, wready, bvalid, arready, rvalid, rate, irq;
   wire [1:0] bresp;
   wire [1:0] rresp;
   wire [31:0] rdata;
   int n_errors = 0;
   int check_count = 0;

   revfb_bank uut (.CLK(clk), .SYS_RST(rst), .AWVALID(awvalid), .AWREADY(awready), .AWADDR(awaddr),
      .AWPROT(3'h0), .WVALID(wvalid), .WREADY(wready), .WDATA(wdata), .WSTRB(4'hf), .BVALID(bvalid),
      .BREADY(bready), .BRESP(bresp), .ARVALID(arvalid), .ARREADY(arready), .ARADDR(araddr),
      .ARPROT(3'h0), .RVALID(rvalid), .RREADY(rready), .RDATA(rdata), .RRESP(rresp),
      .EV_ADDR_MISS(pv[0]), .EV_STRENGTH_DONE(pv[1]), .EV_CRC_PASS(pv[3]), .EV_CRC_FAIL(pv[4]),
      .EV_LENGTH_FIELD(pv[5]), .EV_ED_DONE(pv[6]), .EV_ED_STOPPED(pv[7]), .EV_CCA_IDLE(pv[8]),
      .EV_CCA_BUSY(pv[9]), .EV_CCA_STOPPED(pv[10]), .EV_CODING_IND(pv[11]), .EV_TX_RAMPED(pv[12]),
      .EV_RX_RAMPED(pv[13]), .EV_HDR_MATCH(pv[14]), .EV_PREAMBLE(pv[15]), .EV_PHY_END(pv[16]),
      .RADIO_MODE(mode), .RX_ACTIVE(rx_act), .BC_START(pv[17]), .BC_STOP(pv[18]), .BIT_TICK(pv[19]),
      .RX_RATE_500K(rate), .IRQ(irq));

   initial begin
      forever #25 clk = ~clk;
   end

   // ----------------------------------------
   // bus and compare tasks
   // ----------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         n_errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1;
      wvalid <= 1;
      bready <= 1;
      do begin
         @(posedge clk);
         if (awready) awvalid <= 0;
         if (wready) wvalid <= 0;
      end while (bvalid !== 1'b1);
      rsp = bresp;
      bready <= 0;
   endtask : wr

   task automatic rdr(input logic [11:0] a);
      @(posedge clk);
      araddr <= a;
      arvalid <= 1;
      rready <= 1;
      do begin
         @(posedge clk);
         if (arready) arvalid <= 0;
      end while (rvalid !== 1'b1);
      rd = rdata;
      rsp = rresp;
      rready <= 0;
   endtask : rdr

   task automatic rdf(input int i, input logic [31:0] exp);
      rdr(revfb_pkg::FLAG_OFFS[i]);
      chk(rd, exp);
   endtask : rdf

   task automatic pulse(input int i);
      @(posedge clk);
      pv[i] <= 1;
      @(posedge clk);
      pv[i] <= 0;
   endtask : pulse

   task print_verdict;
      $display("checks=%0d errors=%0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : print_verdict

   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_reset;
      for (int i = 0; i < 17; i++) rdf(i, 0);
      rdr(revfb_pkg::BIT_COUNTER_COMPARE_OFF);
      chk(rd, revfb_pkg::COMPARE_RESET);
      rdr(12'h000);
      chk({rd[31:2], rsp}, {30'h0, revfb_pkg::RESP_SLVERR});
      wr(revfb_pkg::IRQ_STATUS_OFF, 0);
      chk({30'h0, rsp}, {30'h0, revfb_pkg::RESP_SLVERR});
      $display("done reset");
   endtask : t_reset

   task automatic t_flags;
      for (int i = 0; i < 17; i++) begin
         if (i != revfb_pkg::IDX_BIT_MATCH) begin
            pulse(i);
            rdf(i, 1);
            wr(revfb_pkg::FLAG_OFFS[i], 1);
            rdf(i, 1);
            wr(revfb_pkg::FLAG_OFFS[i], 0);
            rdf(i, 0);
         end
      end
      $display("done flags");
   endtask : t_flags

   task automatic t_gates;
      mode <= 3'h0;
      pulse(5);
      pulse(15);
      rdf(5, 0);
      rdf(15, 0);
      mode <= revfb_pkg::LONG_RANGE_125K_MODE;
      pulse(15);
      rdf(15, 1);
      wr(revfb_pkg::FLAG_OFFS[15], 0);
      mode <= revfb_pkg::LONG_RANGE_500K_MODE;
      pulse(15);
      rdf(15, 1);
      pulse(11);
      #1 chk({31'h0, rate}, 1);
      rdr(revfb_pkg::RX_RATE_STATE_OFF);
      chk(rd, 1);
      pulse(16);
      #1 chk({31'h0, rate}, 0);
      wr(revfb_pkg::FLAG_OFFS[11], 0);
      wr(revfb_pkg::FLAG_OFFS[15], 0);
      mode <= revfb_pkg::LOWRATE_PAN_250K_MODE;
      rx_act <= 0;
      pulse(11);
      pulse(15);
      #1 chk({31'h0, rate}, 0);
      rdf(11, 0);
      rdf(15, 0);
      rx_act <= 1;
      $display("done gates");
   endtask : t_gates

   task automatic t_bitcount;
      wr(revfb_pkg::BIT_COUNTER_COMPARE_OFF, 3);
      pulse(17);
      for (int k = 0; k < 3; k++) begin
         pulse(19);
         rdf(2, (k == 2));
      end
      wr(revfb_pkg::FLAG_OFFS[2], 0);
      pulse(17);
      pulse(18);
      repeat (3) pulse(19);
      rdf(2, 0);
      $display("done bitcount");
   endtask : t_bitcount

   task automatic t_irq;
      wr(revfb_pkg::IRQ_CLEAR_OFF, 32'h0001ffff);
      wr(revfb_pkg::IRQ_ENABLE_OFF, 32'h00000008);
      rdr(revfb_pkg::IRQ_ENABLE_OFF);
      chk(rd, 32'h00000008);
      #1 chk({31'h0, irq}, 0);
      pulse(3);
      #1 chk({31'h0, irq}, 0);
      @(posedge clk);
      #1 chk({31'h0, irq}, 1);
      wr(revfb_pkg::IRQ_CLEAR_OFF, 32'h00000008);
      repeat (2) @(posedge clk);
      #1 chk({31'h0, irq}, 0);
      pulse(4);
      repeat (3) @(posedge clk);
      #1 chk({31'h0, irq}, 0);
      rdr(revfb_pkg::IRQ_STATUS_OFF);
      chk(rd, 32'h00000010);
      $display("done irq");
   endtask : t_irq

   initial begin
      repeat (8) @(posedge clk);
      rst <= 0;
      t_reset();
      t_flags();
      t_gates();
      t_bitcount();
      t_irq();
      print_verdict();
   end

   initial begin
      #1000000;
      n_errors++;
      print_verdict();
   end
endmodule : revfb_bank_tb
